// File: rtl/oag_map.vh
`ifndef OAG_MAP_VH
`define OAG_MAP_VH
// Addressing modes, binary request codes
`define OAG_MODE_REG      4'h0
`define OAG_MODE_WORK     4'h1
`define OAG_MODE_PTR      4'h2
`define OAG_MODE_BASE_RF  4'h3
`define OAG_MODE_BASE_MS  4'h4
`define OAG_MODE_BASE_ML  4'h5
`define OAG_MODE_DIRECT   4'h6
`define OAG_MODE_INDIRECT 4'h7
`define OAG_MODE_REL      4'h8
`define OAG_MODE_LIT      4'h9
`define OAG_MODE_PUSH     4'hA
`define OAG_MODE_POP      4'hB
// Instruction classes
`define OAG_INS_OTHER     4'h0
`define OAG_INS_LOAD_REG  4'h1
`define OAG_INS_LOAD_PROG 4'h2
`define OAG_INS_LOAD_EXT  4'h3
`define OAG_INS_JUMP      4'h4
`define OAG_INS_CALL      4'h5
`define OAG_INS_BIT_JF    4'h6
`define OAG_INS_BIT_JT    4'h7
`define OAG_INS_DEC_JNZ   4'h8
`define OAG_INS_CMP_JEQ   4'h9
`define OAG_INS_CMP_JNE   4'hA
`define OAG_INS_SHORT_JR  4'hB
// Targets
`define OAG_TGT_NONE      2'h0
`define OAG_TGT_RF        2'h1
`define OAG_TGT_PROG      2'h2
`define OAG_TGT_EXT       2'h3
// Protected control block bounds and reset pointer values
`define OAG_CTRL_LO       8'hC0
`define OAG_PTR0_RST      8'hC0
`define OAG_PTR1_RST      8'hC8
`define OAG_WORK_PREFIX   4'hC
`endif

// File: rtl/oag_core.v
`include "oag_map.vh"
`default_nettype none
// Function
// RULE1: seven addressing modes, not all per instruction
// RULE2: register mode yields register or pair value
// RULE3: pointer picks slice, field picks byte
// RULE4: pointer mode uses register as address
// RULE5: byte pointers for file, pairs for memory
// RULE6: pointer mode never reaches set-1 control block
// RULE7: base-offset never reaches set-1 control block
// RULE8: short offset signed, memory accesses only
// RULE9: file base plus working register offset
// RULE10: memory base from pair plus instruction offset
// RULE11: file base-offset only for register load
// RULE12: direct address loads PC for jump/call
// RULE13: memory loads accept direct address either way
// RULE14: indirect reads vector in lowest 256 bytes
// RULE15: indirect mode only for call
// RULE16: relative adds signed displacement to PC
// RULE17: PC base is next instruction address
// RULE18: relative only for listed jump instructions
// RULE19: literal operand taken from instruction field
// RULE20: predecrement on push, postincrement on pop
// RULE21: top bit picks pointer, five plus three
// RULE22: pair MSB even register, LSB odd
// RULE23: sign-extend displacements, wrap modulo 65536
module oag_core (
  input  wire        CLK_SYS,
  input  wire        RESET_N,
  input  wire        REQ_VALID,
  input  wire [3:0]  REQ_MODE,
  input  wire [3:0]  REQ_INSTR,
  input  wire        REQ_WORD,
  input  wire        REQ_SET1,
  input  wire [7:0]  REQ_FIELD,
  input  wire [15:0] REQ_IMM,
  input  wire [15:0] REQ_NEXT_PC,
  input  wire [7:0]  RF_BYTE,
  input  wire [7:0]  RF_BYTE_ODD,
  input  wire [7:0]  VEC_HI,
  input  wire [7:0]  VEC_LO,
  input  wire [15:0] STACK_PTR,
  input  wire        PTR_WE,
  input  wire        PTR_SEL,
  input  wire [7:0]  PTR_WDATA,
  output reg         ACK_VALID,
  output reg         ACK_ERROR,
  output reg  [1:0]  ACK_TARGET,
  output reg  [15:0] ACK_ADDR,
  output reg  [15:0] ACK_OPERAND,
  output reg         ACK_PC_LOAD,
  output reg  [15:0] ACK_NEW_SP,
  output reg  [7:0]  WORK_PTR0,
  output reg  [7:0]  WORK_PTR1
);

  reg         ack_valid_d;   // Next answer strobe
  reg         ack_error_d;   // Next refusal flag
  reg  [1:0]  ack_target_d;  // Next target space
  reg  [15:0] ack_addr_d;    // Next effective address
  reg  [15:0] ack_operand_d; // Next operand value
  reg         ack_pc_load_d; // Next PC load flag
  reg  [15:0] ack_new_sp_d;  // Next stack address
  reg  [7:0]  rf_addr;       // Register file address scratch
  reg  [7:0]  work_ptr;      // Chosen working pointer
  wire [15:0] field_sext;    // Sign-extended 8-bit field
  wire        mem_load;      // Program or external load
  wire        rel_ok;        // Instruction may use relative mode
  wire [1:0]  mem_tgt;       // Target of a memory load

  // Offsets are widened before the add, so a negative step wraps
  // modulo 64K instead of carrying into a wider sum
  // Signed displacement widened to 16 bits
  assign field_sext = {{8{REQ_FIELD[7]}}, REQ_FIELD}; // see RULE23
  assign mem_load = (REQ_INSTR == `OAG_INS_LOAD_PROG) || (REQ_INSTR == `OAG_INS_LOAD_EXT);
  assign mem_tgt = (REQ_INSTR == `OAG_INS_LOAD_PROG) ? `OAG_TGT_PROG : `OAG_TGT_EXT;
  // Relative mode instruction set
  assign rel_ok = (REQ_INSTR == `OAG_INS_BIT_JF) || (REQ_INSTR == `OAG_INS_BIT_JT) ||
                  (REQ_INSTR == `OAG_INS_DEC_JNZ) || (REQ_INSTR == `OAG_INS_CMP_JEQ) ||
                  (REQ_INSTR == `OAG_INS_CMP_JNE) ||
                  (REQ_INSTR == `OAG_INS_SHORT_JR); // see RULE18

  // Working register pointer 0, chosen by field bit 3 low
  // A write lands at the next edge; a request in the same cycle
  // still works from the old pointer value
  always @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      WORK_PTR0 <= `OAG_PTR0_RST;          // Slice C0h after reset
    end else if (PTR_WE && !PTR_SEL) begin
      WORK_PTR0 <= PTR_WDATA;              // see RULE3
    end
  end

  // Working register pointer 1, chosen by field bit 3 high
  always @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      WORK_PTR1 <= `OAG_PTR1_RST;          // Slice C8h after reset
    end else if (PTR_WE && PTR_SEL) begin
      WORK_PTR1 <= PTR_WDATA;              // see RULE3
    end
  end

  // Purely combinational on the request: the caller must present the
  // register file and vector bytes that belong to this request in
  // the same cycle. Refused requests never stall; they come back
  // flagged, with no target and no PC load
  // Address and operand generation per mode
  always @* begin
    ack_valid_d   = REQ_VALID;
    ack_error_d   = 1'b0;
    ack_target_d  = `OAG_TGT_NONE;
    ack_addr_d    = 16'h0000;
    ack_operand_d = 16'h0000;
    ack_pc_load_d = 1'b0;
    ack_new_sp_d  = STACK_PTR;
    // Working address: pointer high five bits plus field low three
    work_ptr = REQ_FIELD[3] ? WORK_PTR1 : WORK_PTR0;  // see RULE21
    rf_addr  = {work_ptr[7:3], REQ_FIELD[2:0]};        // see RULE3
    case (REQ_MODE)  // see RULE1
      `OAG_MODE_REG: begin
        // Value of named register, pair high byte even
        // Field top nibble Ch means a working register, not location Cxh
        ack_target_d = `OAG_TGT_RF;
        if (REQ_FIELD[7:4] == `OAG_WORK_PREFIX) begin
          ack_addr_d = {8'h00, rf_addr};
        end else begin
          ack_addr_d = {8'h00, REQ_FIELD};
        end
        if (REQ_WORD) begin
          ack_addr_d[0] = 1'b0;
          ack_operand_d = {RF_BYTE, RF_BYTE_ODD};  // see RULE22
        end else begin
          ack_operand_d = {8'h00, RF_BYTE};        // see RULE2
        end
      end
      `OAG_MODE_WORK: begin
        // 4-bit working register address
        ack_target_d  = `OAG_TGT_RF;
        ack_addr_d    = {8'h00, rf_addr};            // see RULE3
        ack_operand_d = REQ_WORD ? {RF_BYTE, RF_BYTE_ODD} : {8'h00, RF_BYTE};
      end
      `OAG_MODE_PTR: begin
        // Register contents become the address
        // Word pointers reach program or external space, never the file,
        // so the control block guard applies to byte pointers only
        if (REQ_WORD) begin
          ack_addr_d   = {RF_BYTE, RF_BYTE_ODD};     // see RULE5
          ack_target_d = mem_load ? mem_tgt : `OAG_TGT_PROG; // see RULE4
        end else begin
          ack_addr_d   = {8'h00, RF_BYTE};           // see RULE4
          ack_target_d = `OAG_TGT_RF;
          ack_error_d  = REQ_SET1 && (RF_BYTE >= `OAG_CTRL_LO); // see RULE6
        end
      end
      `OAG_MODE_BASE_RF: begin
        // Instruction base plus working register offset
        // Sum wraps in 8 bits; the guard sees the wrapped address
        ack_target_d = `OAG_TGT_RF;
        rf_addr      = REQ_FIELD + RF_BYTE;          // see RULE9
        ack_addr_d   = {8'h00, rf_addr};
        ack_error_d  = (REQ_INSTR != `OAG_INS_LOAD_REG) ||
                       (REQ_SET1 && (rf_addr >= `OAG_CTRL_LO)); // see RULE7 RULE11
      end
      `OAG_MODE_BASE_MS: begin
        // Pair base plus signed short offset
        ack_target_d = mem_tgt;
        ack_addr_d   = {RF_BYTE, RF_BYTE_ODD} + field_sext; // see RULE8 RULE10
        ack_error_d  = !mem_load;                          // see RULE8 RULE11
      end
      `OAG_MODE_BASE_ML: begin
        // Pair base plus 16-bit offset
        ack_target_d = mem_tgt;
        ack_addr_d   = {RF_BYTE, RF_BYTE_ODD} + REQ_IMM;   // see RULE10
        ack_error_d  = !mem_load;                          // see RULE11
      end
      `OAG_MODE_DIRECT: begin
        // Full 16-bit address from instruction
        // Jump and call steer the PC, memory loads steer memory
        ack_addr_d = REQ_IMM;                              // see RULE12
        if ((REQ_INSTR == `OAG_INS_JUMP) || (REQ_INSTR == `OAG_INS_CALL)) begin
          ack_pc_load_d = 1'b1;                            // see RULE12
          ack_target_d  = `OAG_TGT_PROG;
        end else if (mem_load) begin
          ack_target_d = mem_tgt;                          // see RULE13
        end else begin
          ack_error_d = 1'b1;
        end
      end
      `OAG_MODE_INDIRECT: begin
        // Vector in lowest page, its contents feed PC
        // The caller fetches the vector bytes at the page-zero address
        ack_target_d  = `OAG_TGT_PROG;
        ack_addr_d    = {8'h00, REQ_FIELD};              // see RULE14
        ack_operand_d = {VEC_HI, VEC_LO};                // see RULE14
        ack_pc_load_d = (REQ_INSTR == `OAG_INS_CALL);    // see RULE15
        ack_error_d   = (REQ_INSTR != `OAG_INS_CALL);    // see RULE15
      end
      `OAG_MODE_REL: begin
        // Following instruction address plus displacement
        // Only the listed conditional and short jumps may branch
        ack_target_d  = `OAG_TGT_PROG;
        ack_addr_d    = REQ_NEXT_PC + field_sext;        // see RULE16 RULE17 RULE23
        ack_pc_load_d = rel_ok;                          // see RULE18
        ack_error_d   = !rel_ok;                         // see RULE18
      end
      `OAG_MODE_LIT: begin
        // Operand straight from instruction
        // No address and no target: the operand alone
        ack_operand_d = REQ_WORD ? REQ_IMM : {8'h00, REQ_IMM[7:0]}; // see RULE19
      end
      `OAG_MODE_PUSH: begin
        // Decrement before the write
        // Stack lives in the register file
        ack_new_sp_d = STACK_PTR - 16'h0001;             // see RULE20
        ack_addr_d   = ack_new_sp_d;
        ack_target_d = `OAG_TGT_RF;
      end
      `OAG_MODE_POP: begin
        // Read at old address, increment after
        ack_addr_d   = STACK_PTR;
        ack_new_sp_d = STACK_PTR + 16'h0001;             // see RULE20
        ack_target_d = `OAG_TGT_RF;
      end
      default: begin
        // Unused mode codes are refused
        ack_error_d = 1'b1;
      end
    endcase
    // Refused requests select nothing
    // A refused request must never steer a memory or the PC
    if (ack_error_d) begin
      ack_target_d  = `OAG_TGT_NONE;
      ack_pc_load_d = 1'b0;
    end
    // Idle cycles answer with no error, no target and no PC load
    if (!REQ_VALID) begin
      ack_error_d   = 1'b0;
      ack_pc_load_d = 1'b0;
      ack_target_d  = `OAG_TGT_NONE;
    end
  end

  // Answer registers, one process per output so every output leaves
  // straight from its own flop and each reset value is easy to find
  // Answer strobe, one cycle behind the request
  always @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      ACK_VALID <= 1'b0;
    end else begin
      ACK_VALID <= ack_valid_d;
    end
  end

  // Refusal flag
  always @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      ACK_ERROR <= 1'b0;
    end else begin
      ACK_ERROR <= ack_error_d;
    end
  end

  // Target space
  always @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      ACK_TARGET <= `OAG_TGT_NONE;
    end else begin
      ACK_TARGET <= ack_target_d;
    end
  end

  // Effective address
  always @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      ACK_ADDR <= 16'h0000;
    end else begin
      ACK_ADDR <= ack_addr_d;
    end
  end

  // Operand value
  always @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      ACK_OPERAND <= 16'h0000;
    end else begin
      ACK_OPERAND <= ack_operand_d;
    end
  end

  // PC load flag
  always @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      ACK_PC_LOAD <= 1'b0;
    end else begin
      ACK_PC_LOAD <= ack_pc_load_d;
    end
  end

  // Stack address after push or pop
  always @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      ACK_NEW_SP <= 16'h0000;
    end else begin
      ACK_NEW_SP <= ack_new_sp_d;
    end
  end

endmodule
`default_nettype wire

// File: bench/oag_mem.sv
`default_nettype none
// Far-side storage: register file and low program memory, filled with address patterns
module oag_mem (
  input  wire logic [7:0] rf_addr,
  input  wire logic [7:0] vec_addr,
  output logic      [7:0] rf_byte,
  output logic      [7:0] rf_odd,
  output logic      [7:0] vec_hi,
  output logic      [7:0] vec_lo
);
  timeunit 1ns;
  timeprecision 100ps;
  // Named byte, or pair high byte at the even address
  assign rf_byte = rf_addr ^ 8'hA5;
  // Pair low byte always from the odd neighbour
  assign rf_odd  = {rf_addr[7:1], 1'b1} ^ 8'hA5;
  // Vector pair within the lowest 256 bytes
  assign vec_hi  = ~vec_addr;
  assign vec_lo  = ~(vec_addr + 8'h01);
endmodule
`default_nettype wire

// File: bench/oag_core_chk.sv
`include "oag_map.vh"
`default_nettype none
module oag_core_chk (
  input wire logic        CLK_SYS,
  input wire logic        RESET_N,
  input wire logic        REQ_VALID,
  input wire logic [3:0]  REQ_MODE,
  input wire logic [3:0]  REQ_INSTR,
  input wire logic        REQ_WORD,
  input wire logic        REQ_SET1,
  input wire logic [7:0]  REQ_FIELD,
  input wire logic [15:0] REQ_IMM,
  input wire logic [15:0] REQ_NEXT_PC,
  input wire logic [7:0]  RF_BYTE,
  input wire logic [7:0]  VEC_HI,
  input wire logic [7:0]  VEC_LO,
  input wire logic [15:0] STACK_PTR,
  input wire logic        ACK_VALID,
  input wire logic        ACK_ERROR,
  input wire logic [15:0] ACK_ADDR,
  input wire logic [15:0] ACK_OPERAND,
  input wire logic        ACK_PC_LOAD,
  input wire logic [15:0] ACK_NEW_SP
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);
  // Qualified requests per mode
  wire logic        v_rel  = REQ_VALID && REQ_MODE == `OAG_MODE_REL;
  wire logic        v_ia   = REQ_VALID && REQ_MODE == `OAG_MODE_INDIRECT;
  wire logic        v_brf  = REQ_VALID && REQ_MODE == `OAG_MODE_BASE_RF;
  wire logic [7:0]  idx    = REQ_FIELD + RF_BYTE;
  wire logic [15:0] rel_pc = REQ_NEXT_PC + {{8{REQ_FIELD[7]}}, REQ_FIELD};
  a_ack_next_cycle: assert property (
    REQ_VALID |=> ACK_VALID) else $error("answer missing after request");
  a_rel_target: assert property (
    v_rel && REQ_INSTR == `OAG_INS_SHORT_JR |=> ACK_PC_LOAD && ACK_ADDR == $past(rel_pc))
    else $error("relative target wrong");
  a_vector_call: assert property (
    v_ia && REQ_INSTR == `OAG_INS_CALL |=> ACK_ADDR == {8'h00, $past(REQ_FIELD)}
    && ACK_OPERAND == {$past(VEC_HI), $past(VEC_LO)}) else $error("vector call wrong");
  a_vector_only_call: assert property (
    v_ia && REQ_INSTR != `OAG_INS_CALL |=> ACK_ERROR && !ACK_PC_LOAD)
    else $error("vector mode accepted off call");
  a_direct_jump: assert property (
    REQ_VALID && REQ_MODE == `OAG_MODE_DIRECT && REQ_INSTR == `OAG_INS_JUMP
    |=> ACK_PC_LOAD && ACK_ADDR == $past(REQ_IMM)) else $error("direct jump wrong");
  a_ptr_guard: assert property (
    REQ_VALID && REQ_MODE == `OAG_MODE_PTR && !REQ_WORD && REQ_SET1 && RF_BYTE >= 8'hC0
    |=> ACK_ERROR) else $error("pointer reached control block");
  a_base_guard: assert property (
    v_brf && REQ_SET1 && idx >= 8'hC0 |=> ACK_ERROR) else $error("index reached control block");
  a_base_rf_load: assert property (
    v_brf && REQ_INSTR != `OAG_INS_LOAD_REG |=> ACK_ERROR) else $error("file index off load");
  a_push_predec: assert property (
    REQ_VALID && REQ_MODE == `OAG_MODE_PUSH |=> ACK_NEW_SP == $past(STACK_PTR) - 16'h0001
    && ACK_ADDR == ACK_NEW_SP) else $error("push address wrong");
  c_rel: cover property (v_rel);
  c_vector: cover property (v_ia && REQ_INSTR == `OAG_INS_CALL);
  c_guard: cover property (v_brf && REQ_SET1 && idx >= 8'hC0);
endmodule
bind oag_core oag_core_chk chk (.*);
`default_nettype wire

// File: bench/oag_core_test.sv
`include "oag_map.vh"
`default_nettype none
module oag_core_test;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [3:0] md; logic [3:0] ins; logic s1; logic [7:0] fld; logic [7:0] ra;
    logic [15:0] imm; logic err; logic [1:0] tgt; logic [15:0] adr; logic pcl;
  } oag_row_t;
  localparam logic [3:0] M_DIR = `OAG_MODE_DIRECT, M_IND = `OAG_MODE_INDIRECT;
  localparam logic [3:0] M_PTR = `OAG_MODE_PTR, M_BRF = `OAG_MODE_BASE_RF;
  localparam logic [3:0] M_BMS = `OAG_MODE_BASE_MS, M_BML = `OAG_MODE_BASE_ML;
  localparam logic [3:0] L_REG = `OAG_INS_LOAD_REG, L_PRG = `OAG_INS_LOAD_PROG;
  localparam logic [3:0] L_EXT = `OAG_INS_LOAD_EXT, I_JMP = `OAG_INS_JUMP, I_CAL = `OAG_INS_CALL;
  // Ordinary cases: mode, class, set1, field, reg addr, imm, error, target, addr, pc load
  oag_row_t rows [0:13] = '{
    '{`OAG_MODE_REL, L_REG, 1'b0, 8'h10, 8'h00, 16'h0000, 1'b1, 2'h0, 16'h0000, 1'b0},
    '{M_DIR, I_JMP, 1'b0, 8'h00, 8'h00, 16'h8123, 1'b0, 2'h2, 16'h8123, 1'b1},
    '{M_DIR, I_CAL, 1'b0, 8'h00, 8'h00, 16'h0456, 1'b0, 2'h2, 16'h0456, 1'b1},
    '{M_DIR, L_PRG, 1'b0, 8'h00, 8'h00, 16'h4000, 1'b0, 2'h2, 16'h4000, 1'b0},
    '{M_DIR, L_EXT, 1'b0, 8'h00, 8'h00, 16'h4001, 1'b0, 2'h3, 16'h4001, 1'b0},
    '{M_IND, I_CAL, 1'b0, 8'h40, 8'h00, 16'h0000, 1'b0, 2'h2, 16'h0040, 1'b1},
    '{M_IND, I_JMP, 1'b0, 8'h40, 8'h00, 16'h0000, 1'b1, 2'h0, 16'h0000, 1'b0},
    '{M_PTR, L_REG, 1'b1, 8'h65, 8'h65, 16'h0000, 1'b1, 2'h0, 16'h0000, 1'b0},
    '{M_PTR, L_REG, 1'b1, 8'h1A, 8'h1A, 16'h0000, 1'b0, 2'h1, 16'h00BF, 1'b0},
    '{M_BRF, L_REG, 1'b1, 8'h80, 8'hE5, 16'h0000, 1'b1, 2'h0, 16'h0000, 1'b0},
    '{M_BRF, L_REG, 1'b1, 8'h80, 8'hA5, 16'h0000, 1'b0, 2'h1, 16'h0080, 1'b0},
    '{M_BRF, L_PRG, 1'b0, 8'h80, 8'hA5, 16'h0000, 1'b1, 2'h0, 16'h0000, 1'b0},
    '{M_BMS, L_EXT, 1'b0, 8'hF0, 8'hA4, 16'h0000, 1'b0, 2'h3, 16'h00F0, 1'b0},
    '{M_BML, L_PRG, 1'b0, 8'h00, 8'hA4, 16'h1000, 1'b0, 2'h2, 16'h1100, 1'b0}};
  logic CLK_SYS = 1'b0, RESET_N = 1'b0, REQ_VALID = 1'b0, REQ_WORD = 1'b0, REQ_SET1 = 1'b0;
  logic [3:0] REQ_MODE = 4'h0, REQ_INSTR = 4'h0;
  logic [7:0] REQ_FIELD = 8'h00, PTR_WDATA = 8'h00, rf_addr = 8'h00;
  logic [15:0] REQ_IMM = 16'h0000, REQ_NEXT_PC = 16'h0000, STACK_PTR = 16'h0000;
  logic PTR_WE = 1'b0, PTR_SEL = 1'b0, ACK_VALID, ACK_ERROR, ACK_PC_LOAD;
  logic [7:0] RF_BYTE, RF_BYTE_ODD, VEC_HI, VEC_LO, WORK_PTR0, WORK_PTR1;
  logic [1:0] ACK_TARGET;
  logic [15:0] ACK_ADDR, ACK_OPERAND, ACK_NEW_SP;
  int fail_count = 0, check_count = 0;
  oag_core dut (.*);
  oag_mem mem (.rf_addr(rf_addr), .vec_addr(REQ_FIELD), .rf_byte(RF_BYTE), .rf_odd(RF_BYTE_ODD),
    .vec_hi(VEC_HI), .vec_lo(VEC_LO));
  always #2 CLK_SYS = ~CLK_SYS;
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // One request, answer visible on return
  task automatic go(input logic [3:0] md, ins, input logic wd, s1, input logic [7:0] fld, ra,
                    input logic [15:0] imm, npc, sp);
    REQ_VALID = 1'b1;
    REQ_MODE = md;
    REQ_INSTR = ins;
    REQ_WORD = wd;
    REQ_SET1 = s1;
    REQ_FIELD = fld;
    rf_addr = ra;
    REQ_IMM = imm;
    REQ_NEXT_PC = npc;
    STACK_PTR = sp;
    @(posedge CLK_SYS);
    #1;
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #20000;
    fail_count++;
    end_of_test;
  end
  initial begin
    oag_row_t r;
    logic [7:0] f;
    repeat (3) @(posedge CLK_SYS);
    #1;
    RESET_N = 1'b1;
    chk("pointer0", 16'h00C0, {8'h00, WORK_PTR0});
    chk("pointer1", 16'h00C8, {8'h00, WORK_PTR1});
    // Table rows back to back
    foreach (rows[i]) begin
      r = rows[i];
      go(r.md, r.ins, r.md inside {M_BMS, M_BML}, r.s1, r.fld, r.ra, r.imm, 16'h0, 16'h0);
      chk("error", {15'h0, r.err}, {15'h0, ACK_ERROR});
      chk("target", {14'h0, r.tgt}, {14'h0, ACK_TARGET});
      chk("pc load", {15'h0, r.pcl}, {15'h0, ACK_PC_LOAD});
      chk("valid", 16'h0001, {15'h0, ACK_VALID});
      if (!r.err) chk("address", r.adr, ACK_ADDR);
    end
    $display("test table done");
    for (int k = `OAG_INS_BIT_JF; k <= `OAG_INS_SHORT_JR; k++) begin
      f = k[0] ? 8'h80 : 8'h7F;
      go(`OAG_MODE_REL, k[3:0], 1'b0, 1'b0, f, 8'h00, 16'h0, 16'hFFC0 + k[15:0], 16'h0);
      chk("relative", 16'hFFC0 + k[15:0] + {{8{f[7]}}, f}, ACK_ADDR);
      chk("relative load", 16'h0001, {15'h0, ACK_PC_LOAD});
    end
    $display("test relative done");
    PTR_WE = 1'b1;
    PTR_SEL = 1'b0;
    PTR_WDATA = 8'h70;
    @(posedge CLK_SYS);
    #1;
    PTR_SEL = 1'b1;
    PTR_WDATA = 8'hA8;
    @(posedge CLK_SYS);
    #1;
    PTR_WE = 1'b0;
    chk("pointer0 write", 16'h0070, {8'h00, WORK_PTR0});
    chk("pointer1 write", 16'h00A8, {8'h00, WORK_PTR1});
    go(`OAG_MODE_WORK, L_REG, 1'b0, 1'b0, 8'h06, 8'h06, 16'h0, 16'h0, 16'h0);
    chk("working low", 16'h0076, ACK_ADDR);
    go(`OAG_MODE_REG, L_REG, 1'b0, 1'b0, 8'hCB, 8'hCB, 16'h0, 16'h0, 16'h0);
    chk("working addr", 16'h00AB, ACK_ADDR);
    go(`OAG_MODE_REG, L_REG, 1'b1, 1'b0, 8'h21, 8'h20, 16'h0, 16'h0, 16'h0);
    chk("pair value", 16'h8584, ACK_OPERAND);
    chk("pair addr", 16'h0020, ACK_ADDR);
    go(`OAG_MODE_LIT, `OAG_INS_OTHER, 1'b1, 1'b0, 8'h00, 8'h00, 16'hBEEF, 16'h0, 16'h0);
    chk("literal word", 16'hBEEF, ACK_OPERAND);
    go(`OAG_MODE_LIT, `OAG_INS_OTHER, 1'b0, 1'b0, 8'h00, 8'h00, 16'h5A9C, 16'h0, 16'h0);
    chk("literal byte", 16'h009C, ACK_OPERAND);
    go(`OAG_MODE_PUSH, `OAG_INS_OTHER, 1'b0, 1'b0, 8'h00, 8'h00, 16'h0, 16'h0, 16'h00FF);
    chk("push sp", 16'h00FE, ACK_NEW_SP);
    go(`OAG_MODE_POP, `OAG_INS_OTHER, 1'b0, 1'b0, 8'h00, 8'h00, 16'h0, 16'h0, 16'h00FE);
    chk("pop sp", 16'h00FF, ACK_NEW_SP);
    chk("pop addr", 16'h00FE, ACK_ADDR);
    $display("test hand cases done");
    RESET_N = 1'b0;
    REQ_VALID = 1'b0;
    @(posedge CLK_SYS);
    #1;
    RESET_N = 1'b1;
    chk("pointer1 again", 16'h00C8, {8'h00, WORK_PTR1});
    chk("pointer0 again", 16'h00C0, {8'h00, WORK_PTR0});
    chk("valid after reset", 16'h0000, {15'h0, ACK_VALID});
    go(M_DIR, I_JMP, 1'b0, 1'b0, 8'h00, 8'h00, 16'h1234, 16'h0, 16'h0);
    chk("first after reset", 16'h1234, ACK_ADDR);
    chk("load after reset", 16'h0001, {15'h0, ACK_PC_LOAD});
    $display("test second reset done");
    end_of_test;
  end
endmodule
`default_nettype wire
